/* File: include/fo_params.svh */
// What this block does
// - Pulse output is a square wave at the set frequency, high for half each period.
// - Without the fast option, setpoints from 0.1 Hz to 10,000 Hz are accepted.
// - With the fast option, setpoints from 0.1 Hz to 100,000 Hz are accepted.
// - Slow output accepts setpoints only up to 100 Hz, with or without the fast option.
// - Channel settings are written and read as parameter record number 128.
// - An echo bit shows whether the run request is present at the generator.
// - A rising run request sets the sequence-active flag.
// - While the run request stays 1, periods follow one another without a stop.
// - A falling run request aborts at once, clearing active flag and generator level.
// - After an abort no pulse appears until the next rising run request.
// - A new setpoint is taken only at the start of the next period.
// - A setpoint change never moves the falling edge or ratio of the current period.
// - Taking a new setpoint may wait up to 10 s when the old frequency was low.
// - With the owner select at 1 the generator drives the pulse output.
// - With the owner select at 0 the output follows the manual level bit.
// - On host halt the output goes to its configured halt behaviour.
// - Halt substitute level is 0 or 1; substitute mode and 0 are the defaults.
`ifndef FO_PARAMS_SVH
`define FO_PARAMS_SVH

`define FO_CLK_HZ    64'd100000000
`define FO_A_CTRL    5'h00
`define FO_A_SETP    5'h04
`define FO_A_RIDX    5'h08
`define FO_A_RDAT    5'h0c
`define FO_A_STS     5'h10
`define FO_A_HALF    5'h14
`define FO_REC_NUM   8'h80
`define FO_F_MIN     32'h3dcccccd
`define FO_F_100     32'h42c80000
`define FO_F_10K     32'h461c4000
`define FO_F_100K    32'h47c35000
`define FO_CFG_RST   4'h0
`define FO_HALF_RST  32'h1dcd6500
`define FO_MAN_BIAS  8'd150
`define FO_DIV_STEPS 7'd64
`define FO_MAX_APPLY_S 10

`endif

/* File: include/fo_pkg.sv */
package fo_pkg;

  typedef enum logic {FO_IDLE, FO_RUN} fo_state_t;

  typedef struct packed {
    logic manual;
    logic owner;
    logic run;
  } fo_ctrl_t;

  typedef struct packed {
    logic subst;
    logic cont;
    logic slow;
    logic fast;
  } fo_cfg_t;

  typedef struct packed {
    logic rec_err;
    logic pend;
    logic pin;
    logic active;
    logic echo;
  } fo_sts_t;

endpackage

/* File: design/fo_half_div.sv */
`timescale 1ns/10ps
`include "fo_params.svh"

module fo_half_div #(
  parameter int QW = 32
) (
  input  wire logic          clk,    // System clock
  input  wire logic          rstn,   // Async reset, active low
  input  wire logic          start,  // Start pulse
  input  wire logic [31:0]   sp,     // Clamped float setpoint in hertz
  output logic               busy,   // Division in progress
  output logic               done,   // Result ready pulse
  output logic [QW-1:0]      half    // Half period in clock cycles
);
  import fo_pkg::*;

  logic [63:0]   dvd_r, dvd_nxt;
  logic [24:0]   rem_r, rem_nxt;
  logic [23:0]   dvs_r, dvs_nxt;
  logic [6:0]    cnt_r, cnt_nxt;
  logic          busy_nxt, done_nxt;
  logic [QW-1:0] half_nxt;
  logic [24:0]   trial;
  logic [7:0]    shift;

  // --------------------------------------------------------------
  // Half period = (clock / 2) / f, restoring division
  // --------------------------------------------------------------
  always_comb begin
    dvd_nxt  = dvd_r;
    rem_nxt  = rem_r;
    dvs_nxt  = dvs_r;
    cnt_nxt  = cnt_r;
    busy_nxt = busy;
    done_nxt = 1'b0;
    half_nxt = half;
    shift    = `FO_MAN_BIAS - sp[30:23];
    trial    = {rem_r[23:0], dvd_r[63]};
    if (start) begin
      dvd_nxt  = (`FO_CLK_HZ >> 1) << shift[5:0];
      dvs_nxt  = {1'b1, sp[22:0]};
      rem_nxt  = '0;
      cnt_nxt  = `FO_DIV_STEPS;
      busy_nxt = 1'b1;
    end else if (busy) begin
      if (trial >= {1'b0, dvs_r}) begin
        rem_nxt = trial - {1'b0, dvs_r};
        dvd_nxt = {dvd_r[62:0], 1'b1};
      end else begin
        rem_nxt = trial;
        dvd_nxt = {dvd_r[62:0], 1'b0};
      end
      cnt_nxt = cnt_r - 7'd1;
      if (cnt_r == 7'd1) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        half_nxt = (dvd_nxt[QW-1:0] == '0) ? QW'(1) : dvd_nxt[QW-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dvd_r <= '0;
      rem_r <= '0;
      dvs_r <= '0;
      cnt_r <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
      half  <= QW'(`FO_HALF_RST);
    end else begin
      dvd_r <= dvd_nxt;
      rem_r <= rem_nxt;
      dvs_r <= dvs_nxt;
      cnt_r <= cnt_nxt;
      busy  <= busy_nxt;
      done  <= done_nxt;
      half  <= half_nxt;
    end
  end

endmodule

/* File: design/fo_freq_out.sv */
`timescale 1ns/10ps
`include "fo_params.svh"

module fo_freq_out #(
  parameter int QW = 32
) (
  input  wire logic        clk,                  // System clock, 100 MHz
  input  wire logic        rstn,                 // Async reset, active low
  input  wire logic [4:0]  avs_address,          // Byte address
  input  wire logic        avs_read,             // Read request
  input  wire logic        avs_write,            // Write request
  input  wire logic [31:0] avs_writedata,        // Write data
  input  wire logic [3:0]  avs_byteenable,       // Byte lanes
  output logic [31:0]      avs_readdata,         // Read data
  output logic             avs_waitrequest,      // Stall
  input  wire logic        host_halt,            // Host in halt state
  output logic             pulse_output_pin,     // Pulse output
  output logic             sequence_active_flag, // Sequence running
  output logic             run_request_echo      // Run request seen
);
  import fo_pkg::*;

  // --------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------
  fo_ctrl_t      ctrl_r, ctrl_nxt;
  fo_cfg_t       cfg_r, cfg_nxt;
  fo_state_t     state_r, state_nxt;
  fo_sts_t       sts;
  logic [31:0]   setp_r, setp_nxt;
  logic [7:0]    ridx_r, ridx_nxt;
  logic          rec_err_r, rec_err_nxt;
  logic [31:0]   rdata_nxt;
  logic          wait_nxt;
  logic          req, acc;
  logic          run_prev_r;
  logic          lvl_r, lvl_nxt;
  logic          act_nxt, pin_nxt;
  logic [QW-1:0] cnt_r, cnt_nxt;
  logic [QW-1:0] cur_r, cur_nxt;
  logic [QW-1:0] new_r, new_nxt;
  logic          pend_r, pend_nxt;
  logic [31:0]   fmax, fclamp;
  logic [31:0]   last_r, last_nxt;
  logic          start_r, start_nxt;
  logic          div_busy, div_done;
  logic [QW-1:0] div_half;
  logic          load;

  function automatic logic [31:0] fo_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // --------------------------------------------------------------
  // Avalon slave: one wait cycle, then the answer
  // --------------------------------------------------------------
  assign req = avs_read | avs_write;
  assign acc = req & ~avs_waitrequest;

  assign sts.rec_err = rec_err_r;
  assign sts.pend    = pend_r;
  assign sts.pin     = pulse_output_pin;
  assign sts.active  = sequence_active_flag;
  assign sts.echo    = run_request_echo;

  always_comb begin
    wait_nxt    = ~(req & avs_waitrequest);
    ctrl_nxt    = ctrl_r;
    setp_nxt    = setp_r;
    ridx_nxt    = ridx_r;
    cfg_nxt     = cfg_r;
    rec_err_nxt = rec_err_r;
    rdata_nxt   = avs_readdata;
    if (avs_read & avs_waitrequest) begin
      unique case (avs_address)
        `FO_A_CTRL: rdata_nxt = 32'(ctrl_r);
        `FO_A_SETP: rdata_nxt = setp_r;
        `FO_A_RIDX: rdata_nxt = 32'(ridx_r);
        `FO_A_RDAT: rdata_nxt = (ridx_r == `FO_REC_NUM) ? 32'(cfg_r) : 32'h0;
        `FO_A_STS:  rdata_nxt = 32'(sts);
        `FO_A_HALF: rdata_nxt = 32'(cur_r);
        default:    rdata_nxt = 32'h0;
      endcase
    end
    if (acc & avs_write) begin
      unique case (avs_address)
        `FO_A_CTRL: begin
          if (avs_byteenable[0]) begin
            ctrl_nxt = fo_ctrl_t'(avs_writedata[2:0]);
          end
        end
        `FO_A_SETP: setp_nxt = fo_merge(setp_r, avs_writedata, avs_byteenable);
        `FO_A_RIDX: begin
          if (avs_byteenable[0]) begin
            ridx_nxt    = avs_writedata[7:0];
            rec_err_nxt = 1'b0;
          end
        end
        `FO_A_RDAT: begin
          if (avs_byteenable[0] && ridx_r == `FO_REC_NUM) begin
            cfg_nxt = fo_cfg_t'(avs_writedata[3:0]);
          end
        end
        default: ;
      endcase
    end
    if (acc && avs_address == `FO_A_RDAT && ridx_r != `FO_REC_NUM) begin
      rec_err_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
      ctrl_r          <= '0;
      setp_r          <= 32'h0;
      ridx_r          <= 8'h0;
      cfg_r           <= fo_cfg_t'(`FO_CFG_RST);
      rec_err_r       <= 1'b0;
    end else begin
      avs_waitrequest <= wait_nxt;
      avs_readdata    <= rdata_nxt;
      ctrl_r          <= ctrl_nxt;
      setp_r          <= setp_nxt;
      ridx_r          <= ridx_nxt;
      cfg_r           <= cfg_nxt;
      rec_err_r       <= rec_err_nxt;
    end
  end

  // --------------------------------------------------------------
  // Setpoint range and half period calculation
  // --------------------------------------------------------------
  always_comb begin
    if (cfg_r.slow) begin
      fmax = `FO_F_100;
    end else if (cfg_r.fast) begin
      fmax = `FO_F_100K;
    end else begin
      fmax = `FO_F_10K;
    end
    if (setp_r[31] || setp_r < `FO_F_MIN) begin
      fclamp = `FO_F_MIN;
    end else if (setp_r > fmax) begin
      fclamp = fmax;
    end else begin
      fclamp = setp_r;
    end
    start_nxt = 1'b0;
    last_nxt  = last_r;
    if (!div_busy && !start_r && fclamp != last_r) begin
      start_nxt = 1'b1;
      last_nxt  = fclamp;
    end
  end

  fo_half_div #(
    .QW (QW)
  ) u_div (
    .clk   (clk),
    .rstn  (rstn),
    .start (start_r),
    .sp    (last_r),
    .busy  (div_busy),
    .done  (div_done),
    .half  (div_half)
  );

  // --------------------------------------------------------------
  // Square wave generator
  // --------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    lvl_nxt   = lvl_r;
    cnt_nxt   = cnt_r;
    cur_nxt   = cur_r;
    load      = 1'b0;
    new_nxt   = div_done ? div_half : new_r;
    if (!ctrl_r.run) begin
      state_nxt = FO_IDLE;
      lvl_nxt   = 1'b0;
    end else if (!run_prev_r) begin
      state_nxt = FO_RUN;
      lvl_nxt   = 1'b1;
      load      = 1'b1;
    end else if (state_r == FO_RUN) begin
      if (cnt_r <= QW'(1)) begin
        lvl_nxt = ~lvl_r;
        if (!lvl_r) begin
          load = 1'b1;
        end else begin
          cnt_nxt = cur_r;
        end
      end else begin
        cnt_nxt = cnt_r - QW'(1);
      end
    end
    if (load) begin
      cur_nxt = new_r;
      cnt_nxt = new_r;
    end
    pend_nxt = div_done | (pend_r & ~load);
    act_nxt  = (state_nxt == FO_RUN);
    if (host_halt && !cfg_r.cont) begin
      pin_nxt = cfg_r.subst;
    end else if (ctrl_r.owner) begin
      pin_nxt = lvl_nxt;
    end else begin
      pin_nxt = ctrl_r.manual;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r              <= FO_IDLE;
      lvl_r                <= 1'b0;
      cnt_r                <= '0;
      cur_r                <= QW'(`FO_HALF_RST);
      new_r                <= QW'(`FO_HALF_RST);
      pend_r               <= 1'b0;
      run_prev_r           <= 1'b0;
      last_r               <= 32'h0;
      start_r              <= 1'b0;
      pulse_output_pin     <= 1'b0;
      sequence_active_flag <= 1'b0;
      run_request_echo     <= 1'b0;
    end else begin
      state_r              <= state_nxt;
      lvl_r                <= lvl_nxt;
      cnt_r                <= cnt_nxt;
      cur_r                <= cur_nxt;
      new_r                <= new_nxt;
      pend_r               <= pend_nxt;
      run_prev_r           <= ctrl_r.run;
      last_r               <= last_nxt;
      start_r              <= start_nxt;
      pulse_output_pin     <= pin_nxt;
      sequence_active_flag <= act_nxt;
      run_request_echo     <= ctrl_r.run;
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  start_sets_active_a: assert property (
    $rose(ctrl_r.run) |=> sequence_active_flag && lvl_r
  ) else $error("rising run request did not start the sequence");

  abort_clears_a: assert property (
    $fell(ctrl_r.run) |=> !sequence_active_flag && !lvl_r
  ) else $error("abort did not clear flag and level");

  no_pulse_idle_a: assert property (
    !ctrl_r.run |=> !lvl_r ##1 (!lvl_r || $past(ctrl_r.run))
  ) else $error("pulse without run request");

  echo_follows_a: assert property (
    ctrl_r.run ##1 ctrl_r.run |-> run_request_echo
  ) else $error("echo bit missing while run request present");

  owner_gen_a: assert property (
    (!host_halt && ctrl_r.owner) |=> pulse_output_pin == lvl_r
  ) else $error("generator not on output");

  owner_manual_a: assert property (
    (!host_halt && !ctrl_r.owner) |=> pulse_output_pin == $past(ctrl_r.manual)
  ) else $error("manual level not on output");

  halt_subst_a: assert property (
    (host_halt && !cfg_r.cont) |=> pulse_output_pin == $past(cfg_r.subst)
  ) else $error("substitute level not applied in halt");

  halt_continue_a: assert property (
    (host_halt && cfg_r.cont && ctrl_r.owner) |=> pulse_output_pin == lvl_r
  ) else $error("waveform not continued in halt");

  reload_edge_a: assert property (
    $changed(cur_r) |-> $rose(lvl_r)
  ) else $error("half period changed inside a period");

  half_expire_a: assert property (
    ($changed(lvl_r) && $past(sequence_active_flag) && sequence_active_flag)
      |-> $past(cnt_r) <= QW'(1)
  ) else $error("output toggled before counter expired");

  continuous_a: assert property (
    (lvl_r && cnt_r == QW'(1) && ctrl_r.run && $past(ctrl_r.run)) |=> !lvl_r
  ) else $error("period sequence stopped while running");

  range_clamp_a: assert property (
    start_r |-> last_r >= `FO_F_MIN && last_r <= $past(fmax)
  ) else $error("setpoint outside accepted range");

  bus_answer_a: assert property (
    (req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest
  ) else $error("bus answer not one cycle late");

  cover_start_c: cover property ($rose(sequence_active_flag));
  cover_abort_c: cover property (lvl_r ##1 $fell(ctrl_r.run));
  cover_reload_c: cover property (pend_r ##1 !pend_r && $rose(lvl_r));
  cover_halt_c: cover property (host_halt && cfg_r.cont && sequence_active_flag);

endmodule

/* File: verif/fo_host_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Program side of the control interface
// ----------------------------------------
module fo_host_model (
  input  wire logic        clk,             // System clock
  input  wire logic        avs_waitrequest, // Slave stall
  input  wire logic [31:0] avs_readdata,    // Slave read data
  output logic [4:0]       avs_address,     // Byte address
  output logic             avs_read,        // Read request
  output logic             avs_write,       // Write request
  output logic [31:0]      avs_writedata,   // Write data
  output logic [3:0]       avs_byteenable,  // Byte lanes
  output logic             host_halt        // Host halt level
);
  initial begin
    avs_address = 5'h1f;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    host_halt = 1'b0;
  end
  // Setpoints go out as float words in hertz, straight to the registers
  task automatic acc(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    avs_writedata <= ~d;
    avs_address <= ~a;
  endtask
endmodule

/* File: verif/test_frequency_output_channel.sv */
`timescale 1ns/10ps
`include "fo_params.svh"
module test_frequency_output_channel;
  import fo_pkg::*;
  logic clk, rstn;
  logic [4:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, host_halt;
  logic [31:0] avs_writedata, avs_readdata, q, seed;
  logic [3:0] avs_byteenable, m_cfg;
  logic pin, act, echo;
  fo_sts_t sts;
  int n_errors, tests_run, n, f;

  fo_freq_out DUT (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .host_halt(host_halt),
    .pulse_output_pin(pin), .sequence_active_flag(act), .run_request_echo(echo));
  fo_host_model HOST (.clk(clk), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .host_halt(host_halt));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // ----------------------------------------
  // Reference model and helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int half_of(int fr);
    int lim;
    lim = m_cfg[1] ? 100 : (m_cfg[0] ? 100000 : 10000);
    return 50000000 / (fr < lim ? fr : lim);
  endfunction
  function automatic logic [31:0] fbits(int fr);
    int e;
    e = $clog2(fr + 1) - 1;
    return {1'b0, 8'(127 + e), 23'(fr << (23 - e))};
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [4:0] a, logic [31:0] d);
    HOST.acc(1'b1, a, d, q);
  endtask
  task automatic rd(logic [4:0] a, logic [31:0] e, string nm);
    HOST.acc(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  task automatic cfg(logic [3:0] c);
    wr(`FO_A_RDAT, {28'h0, c});
    m_cfg = c;
  endtask
  task automatic setf(int fr);
    wr(`FO_A_SETP, fbits(fr));
    repeat (100) @(posedge clk);
  endtask
  task automatic wait_lvl(logic l);
    int k;
    k = 0;
    while (pin !== l && k < 1200000) begin
      @(negedge clk);
      k++;
    end
  endtask
  task automatic span(logic l, output int c);
    c = 0;
    while (pin === l && c < 1200000) begin
      @(negedge clk);
      c++;
    end
  endtask
  task automatic steady(logic l, string nm);
    int bad;
    bad = 0;
    repeat (1500) begin
      @(negedge clk);
      if (pin !== l) bad++;
    end
    chk(nm, 32'h0, 32'(bad));
  endtask
  task automatic next_half(int e, string nm);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    span(1'b1, n);
    chk(nm, 32'(e), 32'(n));
  endtask
  task automatic test_done();
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #1000000;
    n_errors++;
    test_done();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    seed = 32'ha201;
    m_cfg = 4'h0;
    n_errors = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd(`FO_A_CTRL, 32'h0, "ctrl reset");
    rd(`FO_A_HALF, `FO_HALF_RST, "half reset");
    wr(5'h18, 32'hffffffff);
    rd(5'h18, 32'h0, "unmapped");
    chk("pin idle", 32'h0, {31'h0, pin | act | echo});
    wr(`FO_A_RIDX, 32'h05);
    wr(`FO_A_RDAT, 32'h0f);
    rd(`FO_A_RDAT, 32'h0, "record bad index");
    HOST.acc(1'b0, `FO_A_STS, 32'h0, q);
    sts = q[4:0];
    chk("record error", 32'h1, {31'h0, sts.rec_err});
    wr(`FO_A_RIDX, {24'h0, `FO_REC_NUM});
    rd(`FO_A_RDAT, 32'h0, "record default");
    HOST.acc(1'b0, `FO_A_STS, 32'h0, q);
    sts = q[4:0];
    chk("record error clear", 32'h0, {31'h0, sts.rec_err});
    cfg(4'h1);
    rd(`FO_A_RDAT, 32'h1, "record fast");
    setf(100000);
    wr(`FO_A_CTRL, 32'h3);
    repeat (2) @(negedge clk);
    chk("start", 32'h7, {29'h0, pin, act, echo});
    next_half(half_of(100000), "high half");
    span(1'b0, n);
    chk("low half", 32'(half_of(100000)), 32'(n));
    fork
      begin
        wr(`FO_A_SETP, fbits(50000));
        repeat (100) @(posedge clk);
        rd(`FO_A_STS, 32'h0f, "pending");
      end
      span(1'b1, n);
    join
    chk("old high", 32'(half_of(100000)), 32'(n));
    span(1'b0, n);
    chk("old low", 32'(half_of(100000)), 32'(n));
    span(1'b1, n);
    chk("new high", 32'(half_of(50000)), 32'(n));
    rd(`FO_A_HALF, 32'(half_of(50000)), "half in use");
    repeat (3) begin
      f = 20000 + int'(xs() % 32'd80001);
      setf(f);
      next_half(half_of(f), "random half");
    end
    cfg(4'h0);
    setf(100000);
    next_half(half_of(100000), "clamped half");
    cfg(4'h2);
    setf(99999);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    rd(`FO_A_HALF, 32'(half_of(99999)), "slow half");
    wr(`FO_A_CTRL, 32'h2);
    repeat (2) @(negedge clk);
    chk("abort", 32'h0, {29'h0, pin, act, echo});
    steady(1'b0, "after abort");
    cfg(4'h9);
    setf(100000);
    wr(`FO_A_CTRL, 32'h3);
    @(posedge clk);
    HOST.host_halt <= 1'b1;
    repeat (2) @(negedge clk);
    steady(1'b1, "halt level");
    @(posedge clk);
    HOST.host_halt <= 1'b0;
    cfg(4'h5);
    @(posedge clk);
    HOST.host_halt <= 1'b1;
    next_half(half_of(100000), "halt continue");
    @(posedge clk);
    HOST.host_halt <= 1'b0;
    wr(`FO_A_CTRL, 32'h1);
    repeat (2) @(negedge clk);
    chk("manual active", 32'h1, {31'h0, act});
    steady(1'b0, "manual low");
    wr(`FO_A_CTRL, 32'h4);
    repeat (2) @(negedge clk);
    chk("manual high", 32'h1, {31'h0, pin});
    test_done();
  end
endmodule
